// ===== pkg/sequencer_cfg.svh
`ifndef SEQUENCER_CFG_SVH
`define SEQUENCER_CFG_SVH

// ==========================================================
// Opcodes handled by the sequencer
`define OPC_LOAD_ACC_IMM   8'ha6
`define OPC_JUMP_SUB_EXT   8'hcd
`define OPC_DEC_ACC        8'h4a
`define OPC_BRANCH_NONZERO 8'h26
`define OPC_RETURN_SUB     8'h81
`define OPC_STORE_ACC_DIR  8'hb7

// ==========================================================
// Addressing and reset values
`define DIRECT_PAGE_HIGH   8'h00
`define RESET_PROG_COUNTER 16'h0100
`define RESET_STACK_TOP    16'h00ff
`define RESET_ACC          8'h00

`endif

// ===== pkg/sequencer_pkg.sv
package sequencer_pkg;

  // ========================================================
  // Processor cycle phases, one-hot
  typedef enum logic [15:0] {
    PH_FETCH    = 16'h0001,
    PH_OPERAND1 = 16'h0002,
    PH_OPERAND2 = 16'h0004,
    PH_BUILD    = 16'h0008,
    PH_PUSH_LO  = 16'h0010,
    PH_PUSH_HI  = 16'h0020,
    PH_EXEC1    = 16'h0040,
    PH_EXEC2    = 16'h0080,
    PH_BRANCH   = 16'h0100,
    PH_POP_INC1 = 16'h0200,
    PH_READ_HI  = 16'h0400,
    PH_POP_INC2 = 16'h0800,
    PH_READ_LO  = 16'h1000,
    PH_LOAD_PC  = 16'h2000,
    PH_FORM     = 16'h4000,
    PH_WRITE    = 16'h8000
  } phase_t;

  typedef enum logic {
    ALU_LOAD = 1'b0,
    ALU_DEC  = 1'b1
  } alu_op_t;

  // ========================================================
  // Memory request, one per processor cycle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } cpu_bus_t;

  typedef struct packed {
    phase_t      phase;
    logic [7:0]  opcode;
    logic [7:0]  operand;
    logic [7:0]  hiByte;
    logic [15:0] progCounter;
    logic [15:0] stackPointer;
    logic [7:0]  acc;
    logic        flagN;
    logic        flagZ;
    cpu_bus_t    bus;
  } core_state_t;

endpackage : sequencer_pkg

// ===== logic/acc_alu.sv
`timescale 1ns/1ps

module acc_alu
  import sequencer_pkg::*;
(
  input  wire alu_op_t    aluOp,
  input  wire logic [7:0] accIn,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] result,
  output logic            neg,
  output logic            zero
);

  // ========================================================
  // Result and N/Z flags
  always_comb begin
    result = (aluOp == ALU_DEC) ? accIn - 8'h01 : dataIn;
    zero   = (result == 8'h00);
    neg    = result[7];
  end

endmodule : acc_alu

// ===== logic/subroutine_call_sequencer.sv
// How it works
// - Immediate load fetches opcode, then loads the next program byte into accumulator.
// - Subroutine call reads target high byte then low byte, forms 16-bit address.
// - Call writes return low byte at stack pointer, then decrements stack pointer.
// - Call then writes return high byte at new location, decrements stack pointer again.
// - Saved return address is the byte after the three-byte call; then jump.
// - Decrement subtracts one from accumulator and takes exactly three cycles.
// - Branch fetches opcode and offset; adds sign-extended offset when zero flag clear.
// - When zero flag set, branch falls through to the following instruction.
// - Return takes six cycles: increment, read high, increment, read low, load counter.
// - Direct store takes four cycles: opcode, low address, then writes accumulator.
// - Direct address uses zero high byte and fetched operand low byte.
// - Load sets zero flag on zero value; negative follows the top bit.
// - Branch offset is signed two's complement, added only when condition holds.
`timescale 1ns/1ps
`include "sequencer_cfg.svh"

module subroutine_call_sequencer
  import sequencer_pkg::*;
#(
  parameter logic [15:0] RESET_PROG = `RESET_PROG_COUNTER,
  parameter logic [15:0] RESET_STACK = `RESET_STACK_TOP
)(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  memRdata,
  output cpu_bus_t         bus,
  output logic      [7:0]  acc,
  output logic      [15:0] progCounter,
  output logic      [15:0] stackPointer,
  output logic             flagN,
  output logic             flagZ,
  output logic             instrStart
);

  // ========================================================
  // Helpers
  function automatic cpu_bus_t busRead(input logic [15:0] addr);
    return '{addr: addr, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
  endfunction : busRead

  function automatic cpu_bus_t busWrite(input logic [15:0] addr, input logic [7:0] data);
    return '{addr: addr, wdata: data, rd: 1'b0, wr: 1'b1};
  endfunction : busWrite

  function automatic logic [15:0] relTarget(input logic [15:0] base, input logic [7:0] off);
    return base + {{8{off[7]}}, off};
  endfunction : relTarget

  // ========================================================
  // State
  core_state_t s;
  core_state_t next_s;
  alu_op_t     aluOp;
  logic [7:0]  aluResult;
  logic        aluNeg;
  logic        aluZero;

  acc_alu u_alu (
    .aluOp  (aluOp),
    .accIn  (s.acc),
    .dataIn (memRdata),
    .result (aluResult),
    .neg    (aluNeg),
    .zero   (aluZero)
  );

  // ========================================================
  // Sequencing, one phase per processor cycle
  always_comb begin
    next_s = s;
    aluOp  = (s.phase == PH_EXEC2) ? ALU_DEC : ALU_LOAD;
    unique case (s.phase)
      PH_FETCH: begin
        next_s.opcode = memRdata;
        next_s.progCounter = s.progCounter + 16'h0001;
        next_s.bus = '0;
        unique case (memRdata)
          `OPC_LOAD_ACC_IMM, `OPC_JUMP_SUB_EXT, `OPC_BRANCH_NONZERO, `OPC_STORE_ACC_DIR: begin
            next_s.phase = PH_OPERAND1;
            next_s.bus = busRead(s.progCounter + 16'h0001);
          end
          `OPC_DEC_ACC:    next_s.phase = PH_EXEC1;
          `OPC_RETURN_SUB: next_s.phase = PH_POP_INC1;
          // Unknown opcodes are skipped as one-cycle no-ops
          default: begin
            next_s.phase = PH_FETCH;
            next_s.bus = busRead(s.progCounter + 16'h0001);
          end
        endcase
      end
      PH_OPERAND1: begin
        next_s.operand = memRdata;
        next_s.progCounter = s.progCounter + 16'h0001;
        next_s.bus = '0;
        next_s.phase = PH_FETCH;
        if (s.opcode == `OPC_LOAD_ACC_IMM) begin
          next_s.acc = aluResult;
          next_s.flagN = aluNeg;
          next_s.flagZ = aluZero;
          next_s.bus = busRead(s.progCounter + 16'h0001);
        end else if (s.opcode == `OPC_JUMP_SUB_EXT) begin
          next_s.hiByte = memRdata;
          next_s.phase = PH_OPERAND2;
          next_s.bus = busRead(s.progCounter + 16'h0001);
        end else if (s.opcode == `OPC_BRANCH_NONZERO) begin
          next_s.phase = PH_BRANCH;
        end else begin
          next_s.phase = PH_FORM;
        end
      end
      PH_OPERAND2: begin
        next_s.operand = memRdata;
        next_s.progCounter = s.progCounter + 16'h0001;
        next_s.bus = '0;
        next_s.phase = PH_BUILD;
      end
      PH_BUILD: begin
        next_s.bus = busWrite(s.stackPointer, s.progCounter[7:0]);
        next_s.phase = PH_PUSH_LO;
      end
      PH_PUSH_LO: begin
        next_s.stackPointer = s.stackPointer - 16'h0001;
        next_s.bus = busWrite(s.stackPointer - 16'h0001, s.progCounter[15:8]);
        next_s.phase = PH_PUSH_HI;
      end
      PH_PUSH_HI: begin
        next_s.stackPointer = s.stackPointer - 16'h0001;
        next_s.progCounter = {s.hiByte, s.operand};
        next_s.bus = busRead({s.hiByte, s.operand});
        next_s.phase = PH_FETCH;
      end
      PH_EXEC1: begin
        next_s.phase = PH_EXEC2;
      end
      PH_EXEC2: begin
        next_s.acc = aluResult;
        next_s.flagN = aluNeg;
        next_s.flagZ = aluZero;
        next_s.bus = busRead(s.progCounter);
        next_s.phase = PH_FETCH;
      end
      PH_BRANCH: begin
        if (!s.flagZ) begin
          next_s.progCounter = relTarget(s.progCounter, s.operand);
          next_s.bus = busRead(relTarget(s.progCounter, s.operand));
        end else begin
          next_s.bus = busRead(s.progCounter);
        end
        next_s.phase = PH_FETCH;
      end
      PH_POP_INC1: begin
        next_s.stackPointer = s.stackPointer + 16'h0001;
        next_s.bus = busRead(s.stackPointer + 16'h0001);
        next_s.phase = PH_READ_HI;
      end
      PH_READ_HI: begin
        next_s.hiByte = memRdata;
        next_s.bus = '0;
        next_s.phase = PH_POP_INC2;
      end
      PH_POP_INC2: begin
        next_s.stackPointer = s.stackPointer + 16'h0001;
        next_s.bus = busRead(s.stackPointer + 16'h0001);
        next_s.phase = PH_READ_LO;
      end
      PH_READ_LO: begin
        next_s.operand = memRdata;
        next_s.bus = '0;
        next_s.phase = PH_LOAD_PC;
      end
      PH_LOAD_PC: begin
        next_s.progCounter = {s.hiByte, s.operand};
        next_s.bus = busRead({s.hiByte, s.operand});
        next_s.phase = PH_FETCH;
      end
      PH_FORM: begin
        next_s.bus = busWrite({`DIRECT_PAGE_HIGH, s.operand}, s.acc);
        next_s.phase = PH_WRITE;
      end
      PH_WRITE: begin
        next_s.bus = busRead(s.progCounter);
        next_s.phase = PH_FETCH;
      end
      // Only a corrupted one-hot code lands here; restart at the counter
      default: begin
        next_s.bus = busRead(s.progCounter);
        next_s.phase = PH_FETCH;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{phase: PH_FETCH, opcode: 8'h00, operand: 8'h00, hiByte: 8'h00,
             progCounter: RESET_PROG, stackPointer: RESET_STACK, acc: `RESET_ACC,
             flagN: 1'b0, flagZ: 1'b0,
             bus: '{addr: RESET_PROG, wdata: 8'h00, rd: 1'b1, wr: 1'b0}};
    end else begin
      s <= next_s;
    end
  end

  // ========================================================
  // Outputs, all straight from the state register
  assign bus          = s.bus;
  assign acc          = s.acc;
  assign progCounter  = s.progCounter;
  assign stackPointer = s.stackPointer;
  assign flagN        = s.flagN;
  assign flagZ        = s.flagZ;
  // Fetch is bit 0 of the one-hot phase, so no decode sits in front of the pin
  assign instrStart   = s.phase[0];

  // ========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_load_imm_acc: assert property (
    s.phase == PH_FETCH && memRdata == `OPC_LOAD_ACC_IMM
    |=> s.bus.rd && s.bus.addr == s.progCounter ##1 acc == $past(memRdata) && instrStart)
    else $error("immediate load did not take next byte");
  a_call_operands: assert property (
    s.phase == PH_FETCH && memRdata == `OPC_JUMP_SUB_EXT
    |=> s.phase == PH_OPERAND1 ##1 s.phase == PH_OPERAND2 ##1 s.phase == PH_BUILD
        ##1 s.bus.addr == s.stackPointer ##2 progCounter == {s.hiByte, s.operand})
    else $error("call operand sequence wrong");
  a_push_low: assert property (
    s.phase == PH_PUSH_LO
    |-> s.bus.wr && s.bus.addr == stackPointer && s.bus.wdata == progCounter[7:0]
    ##1 stackPointer == $past(stackPointer) - 16'h0001)
    else $error("low return byte push wrong");
  a_push_high: assert property (
    s.phase == PH_PUSH_HI
    |-> s.bus.wr && s.bus.addr == stackPointer && s.bus.wdata == progCounter[15:8]
    ##1 stackPointer == $past(stackPointer) - 16'h0001)
    else $error("high return byte push wrong");
  a_return_addr: assert property (
    s.phase == PH_BUILD |-> progCounter == $past(progCounter, 3) + 16'h0003)
    else $error("return address not past the call");
  a_dec_three: assert property (
    s.phase == PH_FETCH && memRdata == `OPC_DEC_ACC
    |=> !instrStart [*2] ##1 instrStart && acc == $past(acc, 3) - 8'h01)
    else $error("decrement length or value wrong");
  a_branch_target: assert property (
    s.phase == PH_BRANCH && !flagZ
    |=> progCounter == $past(progCounter) + {{8{$past(s.operand[7])}}, $past(s.operand)})
    else $error("taken branch target wrong");
  a_branch_fall: assert property (
    s.phase == PH_BRANCH && flagZ |=> $stable(progCounter) && s.bus.addr == progCounter)
    else $error("untaken branch moved counter");
  a_return_six: assert property (
    s.phase == PH_FETCH && memRdata == `OPC_RETURN_SUB
    |=> !instrStart [*5] ##1 instrStart && stackPointer == $past(stackPointer, 6) + 16'h0002)
    else $error("return length or stack wrong");
  a_store_four: assert property (
    s.phase == PH_FETCH && memRdata == `OPC_STORE_ACC_DIR
    |=> !instrStart ##1 !s.bus.wr ##1 s.bus.wr ##1 instrStart)
    else $error("direct store length wrong");
  a_direct_addr: assert property (
    s.bus.wr && s.phase == PH_WRITE
    |-> s.bus.addr == {`DIRECT_PAGE_HIGH, s.operand} && s.bus.wdata == acc)
    else $error("direct address or data wrong");
  a_flags_follow: assert property (
    $changed(acc) |-> flagZ == (acc == 8'h00) && flagN == acc[7])
    else $error("flags do not follow accumulator");
  a_dec_flags: assert property (
    s.phase == PH_EXEC2 && s.acc == 8'h01 |=> flagZ && !flagN)
    else $error("decrement to zero did not set zero flag");
  a_offset_signed: assert property (
    s.phase == PH_BRANCH && !flagZ && s.operand[7] |=> progCounter < $past(progCounter)
      || $past(progCounter) < 16'h0080)
    else $error("negative offset not sign-extended");

  c_branch_taken: cover property (s.phase == PH_BRANCH && !flagZ);
  c_branch_fall:  cover property (s.phase == PH_BRANCH && flagZ);
  c_call_return:  cover property (s.phase == PH_PUSH_HI ##[1:200] s.phase == PH_LOAD_PC);
  c_store:        cover property (s.phase == PH_WRITE);

endmodule : subroutine_call_sequencer

// ===== tb/cpu_memory_model.sv
`timescale 1ns/1ps

module cpu_memory_model
  import sequencer_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire cpu_bus_t bus,
  output logic [7:0]    memRdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastData;

  // ==========================================================
  // Read port
  // Answers in the same cycle; no wait states exist.
  // Outside a read the line is not held, so it toggles every cycle
  // instead of showing a stale byte the core could wrongly latch.
  always_comb begin
    if (bus.rd) begin
      memRdata = mem[bus.addr];
    end else begin
      memRdata = ~lastData;
    end
  end

  // ==========================================================
  // Write port
  // Stores land on the edge that ends the write cycle.
  // Plain always: the bench also preloads the array by hierarchy.
  always @(posedge ref_clk) begin
    lastData <= memRdata;
    if (bus.wr) begin
      mem[bus.addr] <= bus.wdata;
    end
  end
endmodule : cpu_memory_model

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "sequencer_cfg.svh"
`define CHK(name, exp, got) begin nTests++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", name, exp, got); end end

module tb
  import sequencer_pkg::*;
;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        wr;
    logic [7:0]  acc;
    logic        n;
    logic        z;
    logic [15:0] stk;
    logic [3:0]  cyc;
  } note_t;

  logic        ref_clk;
  logic        sys_rst;
  logic [7:0]  memRdata;
  cpu_bus_t    bus;
  logic [7:0]  acc;
  logic [15:0] progCounter;
  logic [15:0] stackPointer;
  logic        flagN;
  logic        flagZ;
  logic        instrStart;
  int          miscompares = 0;
  int          nTests = 0;
  logic        running = 1'b0;
  logic [3:0]  cyc = 4'h0;
  note_t       q [$];
  logic [7:0]  refMem [0:65535];
  logic [15:0] eProg;
  logic [15:0] eStack;
  logic [7:0]  eAcc;
  logic        eN;
  logic        eZ;

  subroutine_call_sequencer dut_u (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .memRdata    (memRdata),
    .bus         (bus),
    .acc         (acc),
    .progCounter (progCounter),
    .stackPointer(stackPointer),
    .flagN       (flagN),
    .flagZ       (flagZ),
    .instrStart  (instrStart)
  );

  cpu_memory_model mem_u (
    .ref_clk (ref_clk),
    .bus     (bus),
    .memRdata(memRdata)
  );

  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================
  // Program loading and reference execution
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem_u.mem[a] = d;
    refMem[a] = d;
  endtask : put

  task automatic pushFetch(input logic [3:0] c);
    q.push_back('{addr:eProg, data:8'h00, wr:1'b0, acc:eAcc, n:eN, z:eZ, stk:eStack, cyc:c});
  endtask : pushFetch

  task automatic pushWr(input logic [15:0] a, input logic [7:0] d);
    q.push_back('{addr:a, data:d, wr:1'b1, acc:8'h00, n:1'b0, z:1'b0, stk:16'h0000, cyc:4'h0});
    refMem[a] = d;
  endtask : pushWr

  task automatic setAcc(input logic [7:0] v);
    eAcc = v;
    eZ = (v == 8'h00);
    eN = v[7];
  endtask : setAcc

  // Walks the loaded program and notes every fetch and write it expects
  task automatic interp(input logic [15:0] stopAt);
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [15:0] ret;
    int          guard;
    guard = 0;
    pushFetch(4'h0);
    while (eProg != stopAt && guard < 300) begin
      guard++;
      op = refMem[eProg];
      b1 = refMem[eProg + 16'd1];
      b2 = refMem[eProg + 16'd2];
      case (op)
        `OPC_LOAD_ACC_IMM: begin
          setAcc(b1);
          eProg += 16'd2;
          pushFetch(4'd2);
        end
        `OPC_JUMP_SUB_EXT: begin
          ret = eProg + 16'd3;
          pushWr(eStack, ret[7:0]);
          eStack -= 16'd1;
          pushWr(eStack, ret[15:8]);
          eStack -= 16'd1;
          eProg = {b1, b2};
          pushFetch(4'd6);
        end
        `OPC_DEC_ACC: begin
          setAcc(eAcc - 8'h01);
          eProg += 16'd1;
          pushFetch(4'd3);
        end
        `OPC_BRANCH_NONZERO: begin
          eProg += 16'd2;
          if (!eZ) eProg += {{8{b1[7]}}, b1};
          pushFetch(4'd3);
        end
        `OPC_RETURN_SUB: begin
          eProg = {refMem[eStack + 16'd1], refMem[eStack + 16'd2]};
          eStack += 16'd2;
          pushFetch(4'd6);
        end
        `OPC_STORE_ACC_DIR: begin
          pushWr({`DIRECT_PAGE_HIGH, b1}, eAcc);
          eProg += 16'd2;
          pushFetch(4'd4);
        end
        default: begin
          eProg += 16'd1;
          pushFetch(4'd1);
        end
      endcase
    end
  endtask : interp

  task automatic beginTest;
    running = 1'b0;
    @(posedge ref_clk);
    #1 sys_rst = 1'b1;
    for (int i = 0; i < 65536; i++) begin
      mem_u.mem[i] = 8'h9d;
      refMem[i] = 8'h9d;
    end
    q.delete();
    eProg = `RESET_PROG_COUNTER;
    eStack = `RESET_STACK_TOP;
    eAcc = `RESET_ACC;
    eN = 1'b0;
    eZ = 1'b0;
  endtask : beginTest

  task automatic endTest(input string name, input logic [15:0] stopAt);
    int w;
    interp(stopAt);
    repeat (20) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    running = 1'b1;
    w = 0;
    while (q.size() != 0 && w < 2000) begin
      @(posedge ref_clk);
      w++;
    end
    `CHK("pending notes", 0, q.size())
    running = 1'b0;
    $display("Test %s done", name);
  endtask : endTest

  task automatic giveVerdict;
    $display("Checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : giveVerdict

  // ==========================================================
  // Output watcher: settled values are read on the falling edge
  always @(negedge ref_clk) begin
    note_t nt;
    if (running && !sys_rst && (instrStart === 1'b1 || bus.wr === 1'b1)) begin
      if (q.size() == 0) `CHK("spare access", 1'b0, 1'b1)
      else begin
        nt = q.pop_front();
        `CHK("access kind", nt.wr, bus.wr)
        `CHK("address", nt.addr, bus.addr)
        if (nt.wr) `CHK("write data", nt.data, bus.wdata)
        else begin
          `CHK("accumulator", nt.acc, acc)
          `CHK("flags", {nt.n, nt.z}, {flagN, flagZ})
          `CHK("stack pointer", nt.stk, stackPointer)
          `CHK("program counter", nt.addr, progCounter)
          `CHK("read strobe", 1'b1, bus.rd)
          if (nt.cyc != 4'h0) `CHK("cycles", nt.cyc, cyc)
        end
      end
    end
    if (instrStart === 1'b1) cyc <= 4'h1;
    else cyc <= cyc + 4'h1;
  end

  initial begin
    #100000;
    miscompares++;
    giveVerdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] a;
    logic [7:0]  v;
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    void'($urandom(32'hbf4195c9));
    // taken backward, falls through, call target
    beginTest();
    put(16'h0100, 8'ha6); put(16'h0101, 8'h02); put(16'h0102, 8'hcd);
    put(16'h0103, 8'h02); put(16'h0104, 8'h00); put(16'h0105, 8'hb7);
    put(16'h0106, 8'h02); put(16'h0200, 8'h4a); put(16'h0201, 8'h26);
    put(16'h0202, 8'hfd); put(16'h0203, 8'h81);
    endTest("subroutine loop", 16'h0107);
    for (int t = 0; t < 3; t++) begin
      beginTest();
      put(16'h0300, 8'h4a);
      put(16'h0301, 8'h81);
      a = 16'h0100;
      for (int k = 0; k < 24; k++) begin
        v = 8'($urandom);
        case ($urandom % 4)
          0: v = 8'h00;
          1: v = 8'h80;
          default: ;
        endcase
        case ($urandom % 6)
          0: begin put(a, 8'ha6); put(a + 16'd1, v); a += 16'd2; end
          1: begin put(a, 8'h4a); a += 16'd1; end
          2: begin put(a, 8'hb7); put(a + 16'd1, {1'b0, v[6:0]}); a += 16'd2; end
          3: begin put(a, 8'h26); put(a + 16'd1, {5'h00, v[2:0]}); a += 16'd2 + v[2:0]; end
          4: begin put(a, 8'hcd); put(a + 16'd1, 8'h03); put(a + 16'd2, 8'h00); a += 16'd3; end
          default: a += 16'd1;
        endcase
      end
      endTest("random program", a);
    end
    giveVerdict();
  end
endmodule : tb
